// ### ttd_host.sv
// Purpose: application-side driver of the transmit descriptor and data phases
// Assumes: software loads header words, then payload words, then starts
// Notes:   one channel per instance; payload held as dword array
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module ttd_host #(
  parameter int VC_INDEX  = 0,
  parameter int MAX_DWORD = 16
) (
  input  wire logic          ref_clk_i,   // application clock
  input  wire logic          reset_i,     // sync reset, high
  input  wire logic [3:0]    addr_i,      // software address
  input  wire logic [31:0]   wdata_i,     // software write data
  input  wire logic          wr_i,        // write strobe
  input  wire logic          rd_i,        // read strobe
  output logic      [31:0]   rdata_o,     // read data, next cycle
  output logic      [127:0]  tx_desc_o,   // header bus
  output logic               tx_req_o,    // transmit request
  input  wire logic          tx_ack_i,    // device acknowledge
  output logic      [63:0]   tx_data_o,   // payload bus
  output logic               payload_frame_o, // payload framing
  output logic               payload_valid_o, // payload valid
  input  wire logic          payload_wait_state_i // device wait state
);
  initial begin
    if (VC_INDEX < 0 || VC_INDEX >= ttd_pkg::MAX_VC) $error("bad channel index");
    if (MAX_DWORD < 2 || MAX_DWORD > 1024) $error("bad payload depth");
    // the paired read wraps the word index, so the store must be a power of two
    if (MAX_DWORD != (1 << $clog2(MAX_DWORD))) $error("payload depth not a power of two");
  end
  localparam int PW = $clog2(MAX_DWORD);

  // ==========================================================
  // device handshake inputs
  // same clock as the core, so no synchroniser: any delay here would keep
  // the request up past the acknowledge and the header would go out twice
  logic       ack;
  logic       ws;
  assign ack = tx_ack_i;
  assign ws  = payload_wait_state_i;

  // ==========================================================
  // header fields
  function automatic logic [7:0] hdr_byte(input logic [127:0] h, input int n);
    hdr_byte = h[127-8*n -: 8];
  endfunction : hdr_byte

  // header word n, word 0 holding bytes 0 to 3
  function automatic logic [31:0] hdr_word(input logic [127:0] h, input logic [1:0] n);
    hdr_word = h[127-32*n -: 32];
  endfunction : hdr_word

  function automatic logic is_hdr_addr(input logic [3:0] a);
    is_hdr_addr = ((a & 4'hC) == ttd_pkg::ADDR_HDR0);
  endfunction : is_hdr_addr

  logic [127:0] hdr;
  logic [31:0]  pay [MAX_DWORD];
  logic [PW:0]  pay_wr;
  logic         with_data;
  logic         four_dw;
  logic         align_hi;
  logic [9:0]   len;
  logic [7:0]   byte0;
  assign with_data = hdr[ttd_pkg::BIT_WITH_DATA];
  assign four_dw   = hdr[ttd_pkg::FMT_4DW_BIT];
  assign align_hi  = four_dw ? hdr[ttd_pkg::ALIGN_BIT_64]
                             : hdr[ttd_pkg::ALIGN_BIT_32];
  assign len       = hdr[ttd_pkg::LEN_HI:ttd_pkg::LEN_LO];
  assign byte0     = hdr_byte(hdr, 0);

  // ==========================================================
  // transfer engine
  ttd_pkg::ttd_state_t state;
  ttd_pkg::ttd_state_t next_state;
  logic [127:0] next_hdr;
  logic [PW:0]  next_pay_wr;
  logic [PW:0]  rd_ptr;
  logic [PW:0]  next_rd_ptr;
  logic [10:0]  left;
  logic [10:0]  next_left;
  logic         acked;
  logic         next_acked;
  logic         slot_hi;
  logic         next_slot_hi;
  logic [63:0]  data_q;
  logic [63:0]  next_data_q;
  logic         dv;
  logic         next_dv;
  logic         frame;
  logic         next_frame;
  logic         again;
  logic         next_again;
  logic [15:0]  sent;
  logic [15:0]  next_sent;
  logic         start;
  logic         last_phase;
  logic [PW-1:0] rp;

  assign start = wr_i && (addr_i == ttd_pkg::ADDR_CTRL) && wdata_i[0]
                 && (state == ttd_pkg::TTD_IDLE);
  assign rp    = rd_ptr[PW-1:0];
  // last phase: remaining dwords fit in the current beat
  assign last_phase = (left <= (slot_hi ? 11'h001 : 11'h002));

  always_comb begin
    next_state   = state;
    next_hdr     = hdr;
    next_pay_wr  = pay_wr;
    next_rd_ptr  = rd_ptr;
    next_left    = left;
    next_acked   = acked;
    next_slot_hi = slot_hi;
    next_data_q  = data_q;
    // a beat refused by a wait state stays up in every state
    next_dv      = dv && ws;
    next_frame   = frame;
    next_again   = again;
    next_sent    = sent;
    if (wr_i && is_hdr_addr(addr_i) && state == ttd_pkg::TTD_IDLE) begin
      next_hdr[127-32*addr_i[1:0] -: 32] = wdata_i;
    end
    if (wr_i && addr_i == ttd_pkg::ADDR_DATA && pay_wr <= (PW+1)'(MAX_DWORD - 1)
        && state == ttd_pkg::TTD_IDLE) begin
      next_pay_wr = pay_wr + 1'b1;
    end
    case (state)
      ttd_pkg::TTD_IDLE: begin
        if (start) begin
          next_state   = ttd_pkg::TTD_REQ;
          next_again   = wdata_i[1];
          next_rd_ptr  = '0;
          next_left    = (len == 10'h000) ? 11'h400 : {1'b0, len};
          next_slot_hi = align_hi;
          next_acked   = 1'b0;
          next_frame   = with_data;
        end
      end
      ttd_pkg::TTD_REQ: begin
        if (ack) begin
          next_sent = sent + 1'b1;
          if (with_data) begin
            next_state = ttd_pkg::TTD_DATA;
          end else if (again) begin
            next_state = ttd_pkg::TTD_REQ;
          end else begin
            next_state = ttd_pkg::TTD_IDLE;
          end
        end
      end
      ttd_pkg::TTD_DATA: begin
        // a beat is consumed when valid and no wait state
        if (!(dv && ws)) begin
          next_dv     = 1'b1;
          next_data_q = 64'h0;
          if (slot_hi) begin
            next_data_q[63:32] = pay[rp];
            next_rd_ptr = rd_ptr + 1'b1;
            next_left   = left - 11'h001;
          end else begin
            next_data_q[31:0] = pay[rp];
            if (left > 11'h001) begin
              next_data_q[63:32] = pay[PW'(rp + 1'b1)];
              next_rd_ptr = rd_ptr + 2'h2;
              next_left   = left - 11'h002;
            end else begin
              next_rd_ptr = rd_ptr + 1'b1;
              next_left   = left - 11'h001;
            end
          end
          next_slot_hi = 1'b0;
          if (last_phase) begin
            next_frame = 1'b0;
            next_state = again ? ttd_pkg::TTD_REQ : ttd_pkg::TTD_IDLE;
            next_left  = (len == 10'h000) ? 11'h400 : {1'b0, len};
            next_rd_ptr  = '0;
            next_slot_hi = align_hi;
            if (again) begin
              next_frame = 1'b1;
            end
          end
        end else begin
          next_dv = 1'b1;
        end
      end
      default: next_state = ttd_pkg::TTD_IDLE;
    endcase
    if (wr_i && addr_i == ttd_pkg::ADDR_CTRL && wdata_i[2]) begin
      next_again = 1'b0;
      next_pay_wr = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state   <= ttd_pkg::TTD_IDLE;
      hdr     <= 128'h0;
      pay_wr  <= '0;
      rd_ptr  <= '0;
      left    <= 11'h000;
      acked   <= 1'b0;
      slot_hi <= 1'b0;
      data_q  <= 64'h0;
      dv      <= 1'b0;
      frame   <= 1'b0;
      again   <= 1'b0;
      sent    <= 16'h0000;
    end else begin
      state   <= next_state;
      hdr     <= next_hdr;
      pay_wr  <= next_pay_wr;
      rd_ptr  <= next_rd_ptr;
      left    <= next_left;
      acked   <= next_acked;
      slot_hi <= next_slot_hi;
      data_q  <= next_data_q;
      dv      <= next_dv;
      frame   <= next_frame;
      again   <= next_again;
      sent    <= next_sent;
    end
  end

  // payload memory write, no reset needed for data words
  always_ff @(posedge ref_clk_i) begin
    if (wr_i && addr_i == ttd_pkg::ADDR_DATA && state == ttd_pkg::TTD_IDLE
        && pay_wr <= (PW+1)'(MAX_DWORD - 1)) begin
      pay[pay_wr[PW-1:0]] <= wdata_i;
    end
  end

  // ==========================================================
  // outputs
  assign tx_desc_o       = hdr;
  assign tx_req_o        = (state == ttd_pkg::TTD_REQ);
  assign tx_data_o       = data_q;
  assign payload_valid_o = dv;
  assign payload_frame_o = frame;

  // ==========================================================
  // software read port
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = ttd_pkg::RESET_WORD;
    if (rd_i) begin
      case (addr_i)
        ttd_pkg::ADDR_STATUS: next_rdata = {22'h0, byte0, again,
                                            state != ttd_pkg::TTD_IDLE};
        ttd_pkg::ADDR_CNT:    next_rdata = {16'h0, sent};
        default: begin
          if (is_hdr_addr(addr_i)) begin
            next_rdata = hdr_word(hdr, addr_i[1:0]);
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata <= ttd_pkg::RESET_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end
  assign rdata_o = rdata;
endmodule : ttd_host

// ### ttd_pkg.sv
// Purpose: constants for the transmit descriptor-phase host controller
// Assumes: one application clock, header bus bit 127 is byte 0 msb
// Notes:   header field positions are bit indices on the 128-bit bus
package ttd_pkg;
  // ==========================================================
  // widths
  localparam int DESC_W     = 128;
  localparam int DATA_W     = 64;
  localparam int MAX_VC     = 4;
  localparam int LEN_W      = 10;
  // ==========================================================
  // header bus fields
  localparam int BIT_WITH_DATA  = 126;
  localparam int FMT_HI         = 126;
  localparam int FMT_LO         = 125;
  localparam int FMT_4DW_BIT    = 125;
  localparam int LEN_HI         = 105;
  localparam int LEN_LO         = 96;
  localparam int ALIGN_BIT_64   = 2;
  localparam int ALIGN_BIT_32   = 34;
  // ==========================================================
  // software port
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_DATA   = 4'h2;
  localparam logic [3:0] ADDR_HDR0   = 4'h4;
  localparam logic [3:0] ADDR_CNT    = 4'h8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ==========================================================
  typedef enum logic [1:0] {
    TTD_IDLE = 2'b00,
    TTD_REQ  = 2'b01,
    TTD_DATA = 2'b11
  } ttd_state_t;
endpackage : ttd_pkg

// ### ttd_host_monitor.sv
// Purpose: port checker for ttd_host
// Assumes: acknowledge and wait state arrive on the host clock
// Notes:   bound to every ttd_host instance
`timescale 1ns/1ps
module ttd_host_monitor (
  input wire logic          ref_clk_i,            // clock
  input wire logic          reset_i,              // reset
  input wire logic [3:0]    addr_i,               // sw address
  input wire logic [31:0]   wdata_i,              // sw data
  input wire logic          wr_i,                 // sw write
  input wire logic          rd_i,                 // sw read
  input wire logic [31:0]   rdata_o,              // sw read data
  input wire logic [127:0]  tx_desc_o,            // header bus
  input wire logic          tx_req_o,             // request
  input wire logic          tx_ack_i,             // acknowledge
  input wire logic [63:0]   tx_data_o,            // payload bus
  input wire logic          payload_frame_o,      // framing
  input wire logic          payload_valid_o,      // valid
  input wire logic          payload_wait_state_i  // wait state
);
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_req_holds: assert property (tx_req_o && !tx_ack_i |=> tx_req_o)
    else $error("request dropped before acknowledge");
  a_desc_stable: assert property (tx_req_o && $past(tx_req_o) |-> $stable(tx_desc_o))
    else $error("header changed while request pending");
  a_frame_marks: assert property ($rose(tx_req_o) |-> payload_frame_o == tx_desc_o[126])
    else $error("framing does not follow payload bit");
  a_nodata_quiet: assert property (tx_req_o && !tx_desc_o[126] |-> !payload_frame_o)
    else $error("framing on header-only packet");
  a_data_after: assert property ($rose(payload_valid_o) |-> $past(tx_ack_i, 2))
    else $error("payload beat before acknowledge");
  a_beat_held: assert property (payload_valid_o && payload_wait_state_i
      |=> payload_valid_o && $stable(tx_data_o))
    else $error("payload beat dropped under wait state");
  a_frame_last: assert property ($fell(payload_frame_o) |-> payload_valid_o)
    else $error("framing fell without last beat");
  a_start_req: assert property (wr_i && addr_i == ttd_pkg::ADDR_CTRL && wdata_i[0]
      && !tx_req_o && !payload_frame_o && !payload_valid_o |=> tx_req_o)
    else $error("start did not raise request");
  a_rdata_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule : ttd_host_monitor

bind ttd_host ttd_host_monitor u_mon (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .tx_desc_o, .tx_req_o, .tx_ack_i, .tx_data_o, .payload_frame_o, .payload_valid_o,
  .payload_wait_state_i);

// ### ttd_dev_model.sv
// Purpose: transaction-layer side of one transmit channel
// Assumes: ack delay set by the bench
// Notes:   no header checking, like the real core
`timescale 1ns/1ps
module ttd_dev_model #(
  parameter int VC_INDEX = 0
) (
  input wire logic          ref_clk_i,            // clock
  input wire logic          reset_i,              // reset
  input wire logic [3:0]    ack_dly_i,            // cycles before ack
  input wire logic [127:0]  tx_desc_i,            // header bus
  input wire logic          tx_req_i,             // request
  input wire logic [63:0]   tx_data_i,            // payload bus
  input wire logic          payload_valid_i,      // valid
  output logic              tx_ack_o,             // acknowledge
  output logic              payload_wait_state_o, // wait state
  output logic [127:0]      cap_desc_o,           // last accepted header
  output logic [63:0]       beat0_o,              // first beat
  output logic [63:0]       beat1_o,              // second beat
  output logic [3:0]        nbeat_o,              // beats accepted
  output logic [7:0]        acks_o                // acks given
);
  logic [3:0] wait_cnt;
  logic       stalled;
  // throttle while not ready to acknowledge, and stall the first beat of
  // each packet once so that the host must hold a refused beat
  assign payload_wait_state_o = (tx_req_i && !tx_ack_o)
                                || (payload_valid_i && nbeat_o == 4'h0 && !stalled);
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      {tx_ack_o, wait_cnt, stalled, nbeat_o, acks_o} <= '0;
    end else begin
      tx_ack_o <= 1'b0;
      if (payload_valid_i && payload_wait_state_o) stalled <= 1'b1;
      if (payload_valid_i && !payload_wait_state_o) begin
        if (nbeat_o == 4'h0) beat0_o <= tx_data_i;
        if (nbeat_o == 4'h1) beat1_o <= tx_data_i;
        nbeat_o <= nbeat_o + 4'h1;
      end
      // the request seen in the acknowledge cycle is the one just taken
      if (!tx_req_i || tx_ack_o) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == ack_dly_i) begin
        tx_ack_o   <= 1'b1;
        wait_cnt   <= 4'h0;
        cap_desc_o <= tx_desc_i;
        acks_o     <= acks_o + 8'h1;
        nbeat_o    <= 4'h0;
        stalled    <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : ttd_dev_model

// ### tlp_tx_descriptor_phase_tb.sv
// Purpose: register-level tests of ttd_host against the channel model
// Assumes: 20 MHz clock, 20-cycle reset
// Notes:   expectations built from header words written
`timescale 1ns/1ps
module tlp_tx_descriptor_phase_tb;
  logic ref_clk_i, reset_i, wr_i, rd_i, tx_req_o, tx_ack_i, frame, valid, ws;
  logic [3:0] addr_i, ack_dly, nbeat;
  logic [31:0] wdata_i, rdata_o, v;
  logic [127:0] desc, cap;
  logic [63:0] data, b0, b1;
  logic [7:0] acks, base;
  int error_cnt, num_checks;
  ttd_host uut (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .tx_desc_o(desc), .tx_req_o, .tx_ack_i, .tx_data_o(data), .payload_frame_o(frame),
    .payload_valid_o(valid), .payload_wait_state_i(ws));
  ttd_dev_model dev (.ref_clk_i, .reset_i, .ack_dly_i(ack_dly), .tx_desc_i(desc),
    .tx_req_i(tx_req_o), .tx_data_i(data), .payload_valid_i(valid), .tx_ack_o(tx_ack_i),
    .payload_wait_state_o(ws), .cap_desc_o(cap), .beat0_o(b0), .beat1_o(b1),
    .nbeat_o(nbeat), .acks_o(acks));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic load(input logic [127:0] h, input int n);
    wr(ttd_pkg::ADDR_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) wr(ttd_pkg::ADDR_HDR0 + 4'(i), h[127-32*i -: 32]);
    for (int i = 0; i < n; i++) wr(ttd_pkg::ADDR_DATA, 32'hD000_0000 + 32'(i));
  endtask : load
  task automatic run(input logic [31:0] ctrl);
    wr(ttd_pkg::ADDR_CTRL, ctrl);
    v = 32'h1;
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++) rd(ttd_pkg::ADDR_STATUS, v);
  endtask : run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // tests
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wdata_i, ack_dly} = '0;
    reset_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd(ttd_pkg::ADDR_CNT, v);
    check(128'(v), 128'h0);
    load(128'h0000_0001_1111_2222_3333_4444_5555_6666, 0);
    run(32'h1);
    check(cap, 128'h0000_0001_1111_2222_3333_4444_5555_6666);
    check(128'(nbeat), 128'h0);
    rd(ttd_pkg::ADDR_HDR0 + 4'h1, v);
    check(128'(v), 128'h1111_2222);
    $display("test header only done");
    ack_dly <= 4'h5;
    load(128'h4000_0003_0000_00FF_ABCD_0004_0000_0000, 3);
    run(32'h1);
    check(128'(nbeat), 128'h2);
    check(128'(b0[63:32]), 128'hD000_0000);
    check(128'(b1), 128'hD000_0002_D000_0001);
    rd(ttd_pkg::ADDR_STATUS, v);
    check(128'(v), 128'h100);
    $display("test three dword aligned high done");
    load(128'h6000_0002_0000_00FF_0000_0000_1234_5670, 2);
    run(32'h1);
    check(128'(nbeat), 128'h1);
    check(128'(b0), 128'hD000_0001_D000_0000);
    $display("test four dword aligned low done");
    ack_dly <= 4'h1;
    base = acks;
    load(128'h0000_0001_1111_2222_3333_4444_5555_6666, 0);
    wr(ttd_pkg::ADDR_CTRL, 32'h3);
    for (int i = 0; i < 200 && acks < base + 8'h3; i++) @(posedge ref_clk_i);
    run(32'h4);
    check(128'(acks > base + 8'h2), 128'h1);
    rd(ttd_pkg::ADDR_CNT, v);
    check(128'(v), 128'(acks));
    $display("test back to back done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    summarize();
  end
endmodule : tlp_tx_descriptor_phase_tb
